// >>> pkg/serial_port_pkg.sv
// How it works
// - bit rate chosen from 300 to 115200 bit/s, 19200 after reset
// - one bit per line symbol, so bit rate equals symbol rate
// - characters carry 8 or 7 data bits, 8 after reset
// - optional odd or even parity bit after the data, none after reset
// - received character with wrong parity is flagged as an error
// - one or two stop bits end each character; receiver resynchronises on them
// - a receive gap longer than the idle count in characters closes the frame
// - a frame closes at the maximum length even while bytes keep arriving
// - flow control is none or request/clear to send, none after reset
// - with handshaking on, clear to send drops while the receive buffer is full
// - both ends must use the same rate, width, parity and stop bits
// - first port is always RS232; second port selects RS232 or RS485
// - with no protocol selected, received and outgoing data are discarded
// - a checked protocol recomputes the frame check code before accepting
// - the protocol timeout starts when a byte enters the transmit path
package serial_port_pkg;

    // ****************************************************************
    // clock and rates
    // ****************************************************************
    localparam int unsigned CLK_HZ    = 50_000_000;
    localparam int unsigned RATES[10] = '{300, 600, 1200, 2400, 4800,
                                          9600, 19200, 38400, 57600, 115200};
    localparam int          DIV_W     = 18;

    // ****************************************************************
    // register byte offsets
    // ****************************************************************
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_IDLE   = 8'h04;
    localparam logic [7:0] OFS_MAXLEN = 8'h08;
    localparam logic [7:0] OFS_TMO    = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_MASK   = 8'h14;
    localparam logic [7:0] OFS_RXDATA = 8'h18;
    localparam logic [7:0] OFS_TXDATA = 8'h1c;
    localparam logic [7:0] OFS_FRAME  = 8'h20;

    // ****************************************************************
    // control fields and reset values
    // ****************************************************************
    localparam int         CTRL_BAUD   = 0;   // [3:0]
    localparam int         CTRL_SEVEN  = 4;
    localparam int         CTRL_PAR    = 5;   // [6:5] 0 none 1 odd 2 even
    localparam int         CTRL_TWOSTP = 7;
    localparam int         CTRL_RTS    = 8;
    localparam int         CTRL_RS485  = 9;
    localparam int         CTRL_PROTO  = 10;  // [11:10] 0 none 1 raw 2 checked
    localparam logic [3:0] RST_BAUD    = 4'h6;
    localparam logic [1:0] PAR_NONE    = 2'h0;
    localparam logic [1:0] PAR_ODD     = 2'h1;
    localparam logic [1:0] PAR_EVEN    = 2'h2;
    localparam logic [1:0] PROTO_NONE  = 2'h0;
    localparam logic [1:0] PROTO_CHK   = 2'h2;
    localparam logic [10:0] RST_IDLE   = 11'h005;
    localparam logic [10:0] RST_MAXLEN = 11'h640;
    localparam logic [15:0] RST_TMO    = 16'h0000;

    // ****************************************************************
    // status / mask bits
    // ****************************************************************
    localparam int ST_RXBYTE = 0;
    localparam int ST_FRAME  = 1;
    localparam int ST_PARERR = 2;
    localparam int ST_STPERR = 3;
    localparam int ST_OVRRUN = 4;
    localparam int ST_CHKERR = 5;
    localparam int ST_TXDONE = 6;
    localparam int ST_TMO    = 7;

    typedef enum logic [3:0] {
        LN_IDLE  = 4'b0001,
        LN_START = 4'b0010,
        LN_DATA  = 4'b0100,
        LN_STOP  = 4'b1000
    } line_e;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } reg_req_s;

    typedef struct packed {
        logic [3:0]  baud_sel;
        logic        seven;
        logic [1:0]  parity;
        logic        two_stop;
        logic        rtscts;
        logic        rs485;
        logic [1:0]  proto;
        logic [10:0] idle_len;
        logic [10:0] max_len;
        logic [15:0] tmo_len;
        logic [7:0]  status;
        logic [7:0]  mask;
        logic        irq;
        logic [31:0] rdata;
        logic [DIV_W-1:0] tk_div;
        line_e       rx_st;
        logic [DIV_W-1:0] rx_div;
        logic [3:0]  rx_bit;
        logic [8:0]  rx_sh;
        logic        rx_prev;
        logic [7:0]  rx_hold;
        logic        rx_full;
        logic        fr_open;
        logic [10:0] fr_len;
        logic [7:0]  fr_bcc;
        logic [3:0]  idle_bits;
        logic [10:0] idle_chars;
        logic [10:0] last_len;
        logic        last_ok;
        line_e       tx_st;
        logic [DIV_W-1:0] tx_div;
        logic [3:0]  tx_bit;
        logic [8:0]  tx_sh;
        logic        txd;
        logic        de;
        logic        cts;
        logic        tmo_on;
        logic [3:0]  tmo_bits;
        logic [15:0] tmo_chars;
    } port_state_s;

endpackage : serial_port_pkg

// >>> core/serial_port_frame_assembler.sv
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/100ps
module serial_port_frame_assembler
    import serial_port_pkg::*;
#(
    parameter bit SECOND_PORT = 1'b0
) (
    // clock, reset, enable
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        ce,
    // register port
    input  wire reg_req_s    bus_req,
    output logic [31:0]      rdata,
    // serial line
    input  wire logic        rxd,
    output logic             txd,
    output logic             cts,
    output logic             de,
    // interrupt
    output logic             irq
);

    // ****************************************************************
    // helpers
    // ****************************************************************

    // bit period minus one, one clock per count
    // codes above nine run at 19200
    function automatic logic [DIV_W-1:0] baud_div(input logic [3:0] sel);
        int unsigned r;
        r = (sel > 4'h9) ? RATES[6] : RATES[sel];
        return DIV_W'(CLK_HZ / r - 1);
    endfunction : baud_div

    // data plus parity bits in one character
    // nine at most
    function automatic logic [3:0] pay_bits(input logic seven, input logic [1:0] par);
        return (seven ? 4'h7 : 4'h8) + ((par != PAR_NONE) ? 4'h1 : 4'h0);
    endfunction : pay_bits

    // whole character: start, payload, stops
    function automatic logic [3:0] char_bits(input port_state_s st);
        return 4'h1 + pay_bits(st.seven, st.parity) + (st.two_stop ? 4'h2 : 4'h1);
    endfunction : char_bits

    // parity bit that makes the ones count match the setting
    function automatic logic par_bit(input logic [7:0] d, input logic [1:0] par);
        return (par == PAR_ODD) ? ~(^d) : (^d);
    endfunction : par_bit

    // whole block state
    port_state_s s;
    port_state_s next_s;

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        logic [DIV_W-1:0] div;
        logic [3:0]       npay;
        logic             tick;
        logic [7:0]       set;
        logic [7:0]       clr;
        logic [7:0]       byte_in;
        logic             pbit;
        logic             got;
        logic [10:0]      nlen;
        logic [7:0]       nbcc;
        logic [7:0]       tdat;

        // defaults: hold everything but read data and the rxd sample
        div     = baud_div(s.baud_sel);
        npay    = pay_bits(s.seven, s.parity);
        tick    = (s.tk_div == '0);
        set     = '0;
        clr     = '0;
        byte_in = '0;
        pbit    = 1'b0;
        got     = 1'b0;
        nlen    = '0;
        nbcc    = '0;
        tdat    = '0;

        next_s  = s;
        next_s.rdata   = '0;
        next_s.rx_prev = rxd;

        // free running bit tick for idle and timeout counting
        // one divider for both counters
        next_s.tk_div = tick ? div : s.tk_div - 1'b1;

        // ---------------- receiver ----------------
        // edge arms a half-bit wait
        unique case (s.rx_st)
            LN_IDLE: begin
                if (s.rx_prev && !rxd) begin
                    next_s.rx_st  = LN_START;
                    next_s.rx_div = div >> 1;
                end
            end
            LN_START: begin
                if (s.rx_div == '0) begin
                    next_s.rx_div = div;
                    next_s.rx_bit = '0;
                    // glitch shorter than half a bit is dropped
                    next_s.rx_st  = rxd ? LN_IDLE : LN_DATA;
                end else begin
                    next_s.rx_div = s.rx_div - 1'b1;
                end
            end
            LN_DATA: begin
                if (s.rx_div == '0) begin
                    next_s.rx_div = div;
                    next_s.rx_sh[s.rx_bit] = rxd;
                    next_s.rx_bit = s.rx_bit + 1'b1;
                    if (s.rx_bit == npay - 1'b1) begin
                        next_s.rx_st  = LN_STOP;
                        next_s.rx_bit = '0;
                    end
                end else begin
                    next_s.rx_div = s.rx_div - 1'b1;
                end
            end
            LN_STOP: begin
                if (s.rx_div == '0) begin
                    next_s.rx_div = div;
                    if (!rxd) begin
                        // broken stop: drop character, hunt for next edge
                        set[ST_STPERR] = 1'b1;
                        next_s.rx_st   = LN_IDLE;
                    end else if (s.two_stop && s.rx_bit == '0) begin
                        // second stop bit
                        next_s.rx_bit = 4'h1;
                    end else begin
                        got          = 1'b1;
                        next_s.rx_st = LN_IDLE;
                    end
                end else begin
                    next_s.rx_div = s.rx_div - 1'b1;
                end
            end
        endcase

        // ---------------- character accepted ----------------
        // overrun bytes still count
        byte_in = s.seven ? {1'b0, s.rx_sh[6:0]} : s.rx_sh[7:0];
        pbit    = s.seven ? s.rx_sh[7] : s.rx_sh[8];

        if (got && s.proto != PROTO_NONE) begin
            set[ST_RXBYTE] = 1'b1;
            if (s.parity != PAR_NONE && pbit != par_bit(byte_in, s.parity))
                set[ST_PARERR] = 1'b1;
            if (s.rx_full) begin
                set[ST_OVRRUN] = 1'b1;
            end else begin
                next_s.rx_hold = byte_in;
                next_s.rx_full = 1'b1;
            end
            nlen = s.fr_len + 1'b1;
            nbcc = s.fr_bcc ^ byte_in;

            next_s.idle_bits  = '0;
            next_s.idle_chars = '0;
            if (nlen >= s.max_len) begin
                next_s.fr_open  = 1'b0;
                next_s.fr_len   = '0;
                next_s.fr_bcc   = '0;
                next_s.last_len = nlen;
                next_s.last_ok  = (s.proto != PROTO_CHK) || (nbcc == '0);
                set[ST_FRAME]   = 1'b1;
                set[ST_CHKERR]  = (s.proto == PROTO_CHK) && (nbcc != '0);
            end else begin
                next_s.fr_open = 1'b1;
                next_s.fr_len  = nlen;
                next_s.fr_bcc  = nbcc;
            end
        end else if (s.rx_st != LN_IDLE) begin
            // a character on the way is no gap
            next_s.idle_bits  = '0;
            next_s.idle_chars = '0;
        end else if (s.fr_open && tick) begin
            // gap measured in whole character times
            // idle 0: one silent character
            if (s.idle_bits == char_bits(s) - 1'b1) begin
                next_s.idle_bits  = '0;
                next_s.idle_chars = s.idle_chars + 1'b1;
                if (s.idle_chars >= s.idle_len) begin
                    next_s.fr_open    = 1'b0;
                    next_s.fr_len     = '0;
                    next_s.fr_bcc     = '0;
                    next_s.idle_chars = '0;
                    next_s.last_len   = s.fr_len;
                    next_s.last_ok    = (s.proto != PROTO_CHK) || (s.fr_bcc == '0);
                    set[ST_FRAME]     = 1'b1;
                    set[ST_CHKERR]    = (s.proto == PROTO_CHK) && (s.fr_bcc != '0);
                end
            end else begin
                next_s.idle_bits = s.idle_bits + 1'b1;
            end
        end

        // ---------------- transmitter ----------------
        // one character at a time
        unique case (s.tx_st)
            LN_IDLE: begin
                next_s.txd = 1'b1;
                next_s.de  = 1'b0;
            end
            LN_START: begin
                if (s.tx_div == '0) begin
                    next_s.tx_div = div;
                    next_s.tx_st  = LN_DATA;
                    next_s.txd    = s.tx_sh[0];
                    next_s.tx_sh  = {1'b1, s.tx_sh[8:1]};
                    next_s.tx_bit = 4'h1;
                end else begin
                    next_s.tx_div = s.tx_div - 1'b1;
                end
            end
            LN_DATA: begin
                if (s.tx_div == '0) begin
                    next_s.tx_div = div;
                    if (s.tx_bit == npay) begin
                        next_s.tx_st  = LN_STOP;
                        next_s.txd    = 1'b1;
                        next_s.tx_bit = '0;
                    end else begin
                        next_s.txd    = s.tx_sh[0];
                        next_s.tx_sh  = {1'b1, s.tx_sh[8:1]};
                        next_s.tx_bit = s.tx_bit + 1'b1;
                    end
                end else begin
                    next_s.tx_div = s.tx_div - 1'b1;
                end
            end
            LN_STOP: begin
                if (s.tx_div == '0) begin
                    next_s.tx_div = div;
                    if (s.two_stop && s.tx_bit == '0) begin
                        // second stop bit
                        next_s.tx_bit = 4'h1;
                    end else begin
                        next_s.tx_st   = LN_IDLE;
                        set[ST_TXDONE] = 1'b1;
                    end
                end else begin
                    next_s.tx_div = s.tx_div - 1'b1;
                end
            end
        endcase

        // ---------------- protocol timeout ----------------
        // start is not tick aligned
        if (s.tmo_on && tick) begin
            if (s.tmo_bits == char_bits(s) - 1'b1) begin
                next_s.tmo_bits  = '0;
                next_s.tmo_chars = s.tmo_chars + 1'b1;
                if (s.tmo_chars + 1'b1 >= s.tmo_len) begin
                    next_s.tmo_on = 1'b0;
                    set[ST_TMO]   = 1'b1;
                end
            end else begin
                next_s.tmo_bits = s.tmo_bits + 1'b1;
            end
        end

        // ---------------- register writes ----------------
        // land one clock later
        if (bus_req.wr) begin
            unique case (bus_req.addr)
                OFS_CTRL: begin
                    next_s.baud_sel = bus_req.wdata[CTRL_BAUD +: 4];
                    next_s.seven    = bus_req.wdata[CTRL_SEVEN];
                    next_s.parity   = bus_req.wdata[CTRL_PAR +: 2];
                    next_s.two_stop = bus_req.wdata[CTRL_TWOSTP];
                    next_s.rtscts   = bus_req.wdata[CTRL_RTS];
                    // first port has no RS485 driver
                    next_s.rs485    = SECOND_PORT & bus_req.wdata[CTRL_RS485];
                    next_s.proto    = bus_req.wdata[CTRL_PROTO +: 2];
                end
                OFS_IDLE:   next_s.idle_len = bus_req.wdata[10:0];
                OFS_MAXLEN: next_s.max_len  = bus_req.wdata[10:0];
                OFS_TMO:    next_s.tmo_len  = bus_req.wdata[15:0];
                OFS_STATUS: clr             = bus_req.wdata[7:0];
                OFS_MASK:   next_s.mask     = bus_req.wdata[7:0];

                OFS_TXDATA: begin
                    // busy transmitter or no protocol: byte is dropped
                    // parity shifts out last
                    if (s.tx_st == LN_IDLE && s.proto != PROTO_NONE) begin
                        tdat = s.seven ? {1'b0, bus_req.wdata[6:0]} : bus_req.wdata[7:0];
                        next_s.tx_sh = s.seven
                            ? {1'b1, par_bit(tdat, s.parity), tdat[6:0]}
                            : {par_bit(tdat, s.parity), tdat};
                        next_s.tx_st  = LN_START;
                        next_s.tx_div = div;
                        next_s.txd    = 1'b0;
                        next_s.de     = s.rs485;
                        next_s.tmo_on    = (s.tmo_len != '0);
                        next_s.tmo_bits  = '0;
                        next_s.tmo_chars = '0;
                    end
                end
                default: ;
            endcase
        end

        // ---------------- register reads ----------------
        // data stand one cycle only
        if (bus_req.rd) begin
            unique case (bus_req.addr)
                OFS_CTRL: next_s.rdata = {20'h0, s.proto, s.rs485, s.rtscts,
                                          s.two_stop, s.parity, s.seven, s.baud_sel};
                OFS_IDLE:   next_s.rdata = {21'h0, s.idle_len};
                OFS_MAXLEN: next_s.rdata = {21'h0, s.max_len};
                OFS_TMO:    next_s.rdata = {16'h0, s.tmo_len};
                OFS_STATUS: next_s.rdata = {24'h0, s.status};
                OFS_MASK:   next_s.rdata = {24'h0, s.mask};
                OFS_RXDATA: begin
                    next_s.rdata = {23'h0, s.rx_full, s.rx_hold};
                    // reading empties the buffer; a byte arriving now wins unless it overruns
                    if (!(got && s.proto != PROTO_NONE && !s.rx_full))
                        next_s.rx_full = 1'b0;
                end
                OFS_TXDATA: next_s.rdata = {31'h0, (s.tx_st != LN_IDLE)};
                OFS_FRAME:  next_s.rdata = {20'h0, s.last_ok, s.last_len};
                default:    next_s.rdata = '0;
            endcase
        end

        // sticky status: a new event beats the clear
        next_s.status = (s.status & ~clr) | set;
        next_s.irq    = |(next_s.status & next_s.mask);
        // receive buffer full holds off the terminal
        // drops with the store
        next_s.cts    = !(next_s.rtscts && next_s.rx_full);
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    // reset beats the enable
    always_ff @(posedge clock) begin
        if (!nrst) begin
            s          <= '0;
            s.baud_sel <= RST_BAUD;
            s.parity   <= PAR_NONE;
            s.proto    <= PROTO_NONE;
            s.idle_len <= RST_IDLE;
            s.max_len  <= RST_MAXLEN;
            s.tmo_len  <= RST_TMO;
            s.rx_st    <= LN_IDLE;
            // idle level: no false edge
            s.rx_prev  <= 1'b1;
            s.tx_st    <= LN_IDLE;
            s.txd      <= 1'b1;
            s.cts      <= 1'b1;
            s.last_ok  <= 1'b1;

        end else if (ce) begin
            s <= next_s;
        end
    end

    // outputs straight from state flops
    assign rdata = s.rdata;
    assign txd   = s.txd;
    assign cts   = s.cts;
    assign de    = s.de;
    assign irq   = s.irq;

endmodule : serial_port_frame_assembler

// >>> verif/serial_port_monitor.sv
`timescale 1ns/100ps
module serial_port_monitor
    import serial_port_pkg::*;
(
    // clock and reset
    input wire logic        clock,
    input wire logic        nrst,
    input wire logic        ce,
    // register port
    input wire reg_req_s    bus_req,
    input wire logic [31:0] rdata,
    // line and interrupt
    input wire logic        rxd,
    input wire logic        txd,
    input wire logic        cts,
    input wire logic        de,
    input wire logic        irq
);
    // ****
    // shadow of control and mask writes
    // ****
    logic [11:0] ctrl_sh;
    logic [7:0]  mask_sh;
    // a write lands one cycle later, so relations below allow that lag
    always_ff @(posedge clock) begin
        if (!nrst) begin
            ctrl_sh <= '0;
            mask_sh <= '0;
        end else if (ce && bus_req.wr && bus_req.addr == OFS_CTRL) begin
            ctrl_sh <= bus_req.wdata[11:0];
        end else if (ce && bus_req.wr && bus_req.addr == OFS_MASK) begin
            mask_sh <= bus_req.wdata[7:0];
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    a_reset_idle: assert property (disable iff (1'b0) !nrst |=> txd && cts && !de && !irq)
        else $error("outputs not idle after reset");
    a_rdata_quiet: assert property (!$past(bus_req.rd) && $past(ce) |-> rdata == '0)
        else $error("read data outside read slot");
    a_unmapped_zero: assert property ($past(bus_req.rd) && $past(ce)
        && $past(bus_req.addr) > OFS_FRAME
        |-> rdata == '0)
        else $error("unmapped read not zero");
    a_cts_noflow: assert property (!ctrl_sh[8] && !$past(ctrl_sh[8]) |-> cts)
        else $error("cts low without flow control");
    a_de_rs232: assert property (!ctrl_sh[9] && !$past(ctrl_sh[9]) |-> !de)
        else $error("driver enable in rs232 mode");
    a_proto_quiet: assert property (ctrl_sh[11:10] == 2'h0 && $past(ctrl_sh[11:10]) == 2'h0
        |-> txd)
        else $error("transmit with no protocol");
    a_start_len: assert property ($fell(txd) |-> !txd [*8])
        else $error("start bit too short");
    a_bit_stable: assert property ($changed(txd) |=> $stable(txd) [*8])
        else $error("line symbol too short");
    a_irq_cause: assert property (irq |-> (mask_sh | $past(mask_sh) | $past(mask_sh, 2))
        != 8'h00)
        else $error("interrupt while all masked");
    c_irq: cover property ($rose(irq));
    c_cts: cover property ($fell(cts));
    c_tx: cover property ($fell(txd));
endmodule : serial_port_monitor

bind serial_port_frame_assembler serial_port_monitor u_mon (.clock(clock), .nrst(nrst),
    .ce(ce), .bus_req(bus_req), .rdata(rdata), .rxd(rxd), .txd(txd), .cts(cts), .de(de),
    .irq(irq));

// >>> verif/terminal_model.sv
`timescale 1ns/100ps
module terminal_model #(
    parameter int BIT = 434
) (
    // clock and handshake
    input wire logic clock,
    input wire logic cts,
    input wire logic flow,
    // line towards the port
    output logic     rxd
);
    // line rests high between characters
    initial rxd = 1'b1;
    // 8 data bits, even parity, one stop: same settings as the port
    task automatic send(input logic [7:0] b, input bit bad);
        logic [10:0] f;
        int          n;
        f = {1'b1, ^b ^ bad, b, 1'b0};
        n = 0;
        // hold off while the port is full
        while (flow && cts !== 1'b1 && n < 20000) begin
            @(posedge clock);
            n++;
        end
        for (int i = 0; i < 11; i++) begin
            @(posedge clock);
            rxd <= f[i];
            repeat (BIT - 1) @(posedge clock);
        end
    endtask : send
endmodule : terminal_model

// >>> verif/serial_port_frame_assembler_tb.sv
`timescale 1ns/100ps
module serial_port_frame_assembler_tb;
    import serial_port_pkg::*;
    localparam int BIT = 434;
    localparam int CH  = 11 * BIT;
    logic        clock;
    logic        nrst;
    logic        ce;
    reg_req_s    bus_req;
    logic [31:0] rdata;
    logic        rxd;
    logic        txd;
    logic        cts;
    logic        irq;
    logic        flow;
    logic [31:0] d;
    logic [7:0]  b[3];
    int          failures;
    int          check_count;

    serial_port_frame_assembler u_serial_port_frame_assembler (.clock(clock), .nrst(nrst),
        .ce(ce), .bus_req(bus_req), .rdata(rdata), .rxd(rxd), .txd(txd), .cts(cts),
        .de(), .irq(irq));
    terminal_model #(.BIT(BIT)) u_terminal_model (.clock(clock), .cts(cts), .flow(flow),
        .rxd(rxd));

    // ****
    // bus and checking tasks
    // ****
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock);
        bus_req <= '{1'b1, 1'b0, a, v};
        @(posedge clock);
        bus_req <= '0;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clock);
        bus_req <= '{1'b0, 1'b1, a, 32'h0};
        @(posedge clock);
        bus_req <= '0;
        #1 v = rdata;
    endtask : rd
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
            failures++;
        end
    endtask : chk
    function automatic logic [10:0] line_bits(input logic [7:0] v);
        return {1'b1, ^v, v, 1'b0};
    endfunction : line_bits
    // one character on txd, sampled mid-bit
    task automatic tx_line(input logic [10:0] f);
        for (int n = 0; n < 50 && txd !== 1'b0; n++) @(posedge clock);
        repeat (BIT / 2) @(posedge clock);
        for (int i = 0; i < 11; i++) begin
            chk({31'h0, txd}, {31'h0, f[i]});
            repeat (BIT) @(posedge clock);
        end
    endtask : tx_line
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // hang guard, well past the expected run
    initial begin
        repeat (95000) @(posedge clock);
        failures++;
        end_sim;
    end

    // ****
    // main sequence
    // ****
    initial begin
        nrst = 1'b0;
        ce = 1'b1;
        flow = 1'b1;
        bus_req = '0;
        failures = 0;
        check_count = 0;
        void'($urandom(28412));
        repeat (16) @(posedge clock);
        nrst <= 1'b1;
        rd(OFS_CTRL, d);   chk(d, 32'h006);
        rd(OFS_IDLE, d);   chk(d, 32'h005);
        rd(OFS_MAXLEN, d); chk(d, 32'h640);
        rd(8'h40, d);      chk(d, 32'h0);
        // 115200, even parity, flow control, checked frames
        wr(OFS_CTRL, 32'h949);
        wr(OFS_MAXLEN, 32'h3);
        wr(OFS_IDLE, 32'h0);
        wr(OFS_MASK, 32'hff);
        b[0] = 8'($urandom());
        b[1] = 8'($urandom());
        b[2] = b[0] ^ b[1];
        // frame closes at the length limit with a good check byte
        for (int i = 0; i < 3; i++) begin
            u_terminal_model.send(b[i], 1'b0);
            repeat (4) @(posedge clock);
            chk({31'h0, cts}, 32'h0);
            rd(OFS_RXDATA, d); chk(d, {23'h0, 1'b1, b[i]});
            repeat (3) @(posedge clock);
            chk({31'h0, cts}, 32'h1);
        end
        rd(OFS_FRAME, d);  chk(d, 32'h803);
        rd(OFS_STATUS, d); chk(d & 32'h2, 32'h2);
        chk({31'h0, irq}, 32'h1);
        wr(OFS_STATUS, 32'hff);
        repeat (3) @(posedge clock);
        chk({31'h0, irq}, 32'h0);
        // corrupted parity is flagged
        u_terminal_model.send(8'($urandom()), 1'b1);
        repeat (4) @(posedge clock);
        rd(OFS_STATUS, d); chk(d & 32'h4, 32'h4);
        rd(OFS_RXDATA, d);
        repeat (2 * CH) @(posedge clock);
        // lone byte closes on the idle gap; check fails unless zero
        b[0] = 8'($urandom());
        u_terminal_model.send(b[0], 1'b0);
        rd(OFS_RXDATA, d);
        repeat (2 * CH) @(posedge clock);
        rd(OFS_FRAME, d); chk(d, {20'h0, b[0] == 8'h00, 11'h1});
        // transmit path, sampled mid bit
        b[1] = 8'($urandom());
        wr(OFS_TXDATA, {24'h0, b[1]});
        tx_line(line_bits(b[1]));
        // seven data bits, odd parity, two stops
        wr(OFS_CTRL, 32'h4b9);
        wr(OFS_TXDATA, {24'h0, b[2]});
        tx_line({2'h3, ~^b[2][6:0], b[2][6:0], 1'b0});
        // no protocol: received bytes vanish
        wr(OFS_CTRL, 32'h149);
        wr(OFS_STATUS, 32'hff);
        u_terminal_model.send(8'($urandom()), 1'b0);
        repeat (4) @(posedge clock);
        rd(OFS_STATUS, d); chk(d & 32'h1, 32'h0);
        chk({31'h0, cts}, 32'h1);
        end_sim;
    end
endmodule : serial_port_frame_assembler_tb
